// >>> rtl/bsc_boot_flags.sv
`timescale 1ns/1ps
`default_nettype none

module bsc_boot_flags
(
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          npor,
    input  wire logic                          boot_start,
    input  wire logic                          general_pin_zero,
    input  wire bsc_pkg::bsc_level_t           program_level,
    input  wire logic                          proceed_after_factory_flag,
    input  wire logic                          factory_load_done,
    input  wire logic                          user_load_done,
    input  wire bsc_pkg::bsc_load_result_t     load_result,
    input  wire bsc_pkg::bsc_sfr_wr_t          sfr_wr,
    output logic                               crystal_oscillator_en,
    output logic                               user_load_req,
    output logic                               factory_load_req,
    output logic [7:0]                         boot_control_flags,
    output logic [7:0]                         boot_result_byte,
    output logic                               boot_error,
    output logic                               branch_start,
    output logic [15:0]                        branch_addr
);

    // ----------------------------------------
    // boot sequencer
    // ----------------------------------------
    bsc_pkg::bsc_state_t state;
    bsc_pkg::bsc_state_t next_state;
    logic [7:0]          ctrl;
    logic [7:0]          next_ctrl;
    logic                force_fac;
    logic                next_force_fac;
    logic [7:0]          result;
    logic [7:0]          next_result;
    logic                xo_en;
    logic                next_xo_en;
    logic                fac_req;
    logic                next_fac_req;
    logic                usr_req;
    logic                next_usr_req;
    logic                err;
    logic                next_err;
    logic                branch;
    logic                next_branch;
    logic                run_req;
    logic                stop_after_fac;

    // bit 5 lives in a power-on domain: only npor clears it, so a system reset keeps factory behaviour
    always_comb
    begin
        next_force_fac = force_fac;
        // sticky factory mode
        // set-only: a later write of zero must not undo factory mode before power is cycled
        if (sfr_wr.wr && sfr_wr.wdata[bsc_pkg::FORCE_FAC_BIT])
        begin
            next_force_fac = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge npor)
    begin
        if (!npor)
        begin
            force_fac <= 1'b0;
        end
        else
        begin
            force_fac <= next_force_fac;
        end
    end

    // run bit ignored at run level
    assign run_req = (ctrl[bsc_pkg::RUN_SYS_BIT] | ctrl[bsc_pkg::RUN_POR_BIT])
                     && (program_level != bsc_pkg::BSC_LVL_RUN);

    assign stop_after_fac = (program_level == bsc_pkg::BSC_LVL_FACTORY)
                            || ((program_level == bsc_pkg::BSC_LVL_USER)
                                && (force_fac || !proceed_after_factory_flag));

    always_comb
    begin
        next_state   = state;
        next_ctrl    = ctrl;
        next_result  = result;
        next_xo_en   = xo_en;
        next_fac_req = 1'b0;
        next_usr_req = 1'b0;
        next_err     = err;
        next_branch  = 1'b0;
        // reserved bits and the failed status bit not writable; the finished bit is
        if (sfr_wr.wr)
        begin
            next_ctrl = (ctrl & ~bsc_pkg::CTRL_WMASK) | (sfr_wr.wdata & bsc_pkg::CTRL_WMASK);
        end
        unique case (state)
            bsc_pkg::BSC_ST_IDLE:
            begin
                if (boot_start)
                begin
                    next_result = bsc_pkg::RESULT_RESET;
                    next_result[bsc_pkg::PIN0_BIT] = general_pin_zero;
                    next_ctrl[bsc_pkg::FINISHED_BIT] = 1'b0;
                    next_xo_en   = 1'b1;
                    next_fac_req = 1'b1;
                    next_state   = bsc_pkg::BSC_ST_FACTORY;
                end
            end
            bsc_pkg::BSC_ST_FACTORY:
            begin
                if (factory_load_done)
                begin
                    next_result[bsc_pkg::FAC_ERR_HI:bsc_pkg::FAC_ERR_LO] = load_result.factory_load_error;
                    if (stop_after_fac)
                    begin
                        next_state = bsc_pkg::BSC_ST_FINISH;
                    end
                    else
                    begin
                        next_usr_req = 1'b1;
                        next_state   = bsc_pkg::BSC_ST_USER;
                    end
                end
            end
            bsc_pkg::BSC_ST_USER:
            begin
                if (user_load_done)
                begin
                    next_result[bsc_pkg::LATER_BIT] = load_result.later_block_error;
                    next_result[bsc_pkg::FIRST_BIT] = load_result.first_block_error;
                    next_state = bsc_pkg::BSC_ST_FINISH;
                end
            end
            bsc_pkg::BSC_ST_FINISH:
            begin
                next_ctrl[bsc_pkg::FAILED_BIT] = (result != bsc_pkg::RESULT_OK_A);
                next_err = (result != bsc_pkg::RESULT_OK_A) && (result != bsc_pkg::RESULT_OK_B);
                next_ctrl[bsc_pkg::FINISHED_BIT] = 1'b1;
                next_branch = run_req;
                next_state  = bsc_pkg::BSC_ST_DONE;
            end
            bsc_pkg::BSC_ST_DONE:
            begin
                next_state = bsc_pkg::BSC_ST_DONE;
            end
            default:
            begin
                next_state = bsc_pkg::BSC_ST_IDLE;
            end
        endcase
        next_ctrl[bsc_pkg::FORCE_FAC_BIT] = 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state   <= bsc_pkg::BSC_ST_IDLE;
            ctrl    <= bsc_pkg::CTRL_RESET;
            result  <= bsc_pkg::RESULT_RESET;
            xo_en   <= 1'b0;
            fac_req <= 1'b0;
            usr_req <= 1'b0;
            err     <= 1'b0;
            branch  <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            ctrl    <= next_ctrl;
            result  <= next_result;
            xo_en   <= next_xo_en;
            fac_req <= next_fac_req;
            usr_req <= next_usr_req;
            err     <= next_err;
            branch  <= next_branch;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // force bit comes from its own power-on flop; no gate sits on the read path
    assign boot_control_flags    = {2'b00, force_fac, ctrl[4:0]};
    assign boot_result_byte      = result;
    assign crystal_oscillator_en = xo_en;
    assign factory_load_req      = fac_req;
    assign user_load_req         = usr_req;
    assign boot_error            = err;
    assign branch_start          = branch;
    assign branch_addr           = bsc_pkg::START_ADDR;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_fail_flag_tracks: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FINISH) |=> (ctrl[bsc_pkg::FAILED_BIT] == ($past(result) != 8'h00)))
        else $error("failed flag does not follow result byte");

    a_finish_sets_done: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FINISH) |=> ctrl[bsc_pkg::FINISHED_BIT] ##1 ctrl[bsc_pkg::FINISHED_BIT])
        else $error("finished flag not set at end of boot");

    a_branch_when_run: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FINISH && run_req) |=> branch_start && branch_addr == 16'h0000)
        else $error("no branch with run bit set");

    a_run_level_ignore: assert property (@(posedge clk) disable iff (!nrst)
        (program_level == bsc_pkg::BSC_LVL_RUN) |-> !run_req)
        else $error("run bit honoured at run level");

    a_pin_sampled: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_IDLE && boot_start) |=> result[7] == $past(general_pin_zero) && xo_en)
        else $error("pin not sampled at boot start");

    a_factory_code: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FACTORY && factory_load_done)
        |=> result[4:2] == $past(load_result.factory_load_error))
        else $error("factory error code not stored");

    a_force_stops: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FACTORY && factory_load_done && force_fac
         && program_level == bsc_pkg::BSC_LVL_USER) |=> state == bsc_pkg::BSC_ST_FINISH && !usr_req)
        else $error("user load despite force bit");

    a_error_values: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FINISH) |=> err == ($past(result) != 8'h00 && $past(result) != 8'h80))
        else $error("boot error value wrong");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        boot_control_flags[7:6] == 2'b00 && boot_control_flags[3] == 1'b0 && result[6:5] == 2'b00)
        else $error("reserved bit reads nonzero");

    a_later_block_code: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_USER && user_load_done)
        |=> result[1] == $past(load_result.later_block_error))
        else $error("later block error not stored");

    a_first_block_code: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_USER && user_load_done)
        |=> result[0] == $past(load_result.first_block_error))
        else $error("first block error not stored");

    a_por_run_alike: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FINISH && ctrl[bsc_pkg::RUN_POR_BIT]
         && program_level != bsc_pkg::BSC_LVL_RUN) |=> branch_start)
        else $error("power-on run bit not honoured");

    a_force_over_proceed: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FACTORY && factory_load_done && force_fac && proceed_after_factory_flag
         && program_level == bsc_pkg::BSC_LVL_USER) |=> state == bsc_pkg::BSC_ST_FINISH && !usr_req)
        else $error("proceed flag beat force bit");

    a_user_proceeds: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_FACTORY && factory_load_done && !force_fac && proceed_after_factory_flag
         && program_level == bsc_pkg::BSC_LVL_USER) |=> state == bsc_pkg::BSC_ST_USER && usr_req)
        else $error("user load missing without force bit");

    a_xo_off_idle: assert property (@(posedge clk) disable iff (!nrst)
        (state == bsc_pkg::BSC_ST_IDLE) |-> !xo_en)
        else $error("oscillator on before pin sample");

    // only power-on reset may drop the force bit
    a_force_sticky: assert property (@(posedge clk) disable iff (!npor)
        force_fac |=> force_fac)
        else $error("force bit lost without power cycle");

    a_fail_not_soft: assert property (@(posedge clk) disable iff (!nrst)
        (sfr_wr.wr && state != bsc_pkg::BSC_ST_FINISH)
        |=> ctrl[bsc_pkg::FAILED_BIT] == $past(ctrl[bsc_pkg::FAILED_BIT]))
        else $error("failed flag changed by a write");

endmodule

`default_nettype wire

// >>> rtl/bsc_pkg.sv
package bsc_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [7:0]  CTRL_ADDR   = 8'hDD;
    localparam logic [15:0] RESULT_ADDR = 16'h11FF;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int RUN_SYS_BIT   = 0;
    localparam int FINISHED_BIT  = 1;
    localparam int FAILED_BIT    = 2;
    localparam int RUN_POR_BIT   = 4;
    localparam int FORCE_FAC_BIT = 5;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] CTRL_WMASK    = 8'h33;

    // ----------------------------------------
    // result byte fields
    // ----------------------------------------
    localparam int PIN0_BIT     = 7;
    localparam int FAC_ERR_HI   = 4;
    localparam int FAC_ERR_LO   = 2;
    localparam int LATER_BIT    = 1;
    localparam int FIRST_BIT    = 0;
    localparam logic [7:0] RESULT_OK_A = 8'h00;
    localparam logic [7:0] RESULT_OK_B = 8'h80;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [15:0] START_ADDR  = 16'h0000;

    // ----------------------------------------
    // program levels and boot states
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        BSC_LVL_FACTORY = 2'h0,
        BSC_LVL_USER    = 2'h1,
        BSC_LVL_RUN     = 2'h2
    } bsc_level_t;

    typedef enum logic [4:0]
    {
        BSC_ST_IDLE     = 5'h01,
        BSC_ST_FACTORY  = 5'h02,
        BSC_ST_USER     = 5'h04,
        BSC_ST_FINISH   = 5'h08,
        BSC_ST_DONE     = 5'h10
    } bsc_state_t;

    // load results reported by the copy engine
    typedef struct packed
    {
        logic [2:0] factory_load_error;
        logic       later_block_error;
        logic       first_block_error;
    } bsc_load_result_t;

    // register access from the cpu side
    typedef struct packed
    {
        logic       wr;
        logic [7:0] wdata;
    } bsc_sfr_wr_t;

endpackage

// >>> tb/boot_status_control_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none

module boot_status_control_flags_tb;
    logic                      clk;
    logic                      nrst;
    logic                      npor;
    logic                      boot_start;
    logic                      general_pin_zero;
    bsc_pkg::bsc_level_t       program_level;
    logic                      proceed_after_factory_flag;
    logic                      factory_load_done;
    logic                      user_load_done;
    bsc_pkg::bsc_load_result_t load_result;
    bsc_pkg::bsc_load_result_t result_cfg;
    bsc_pkg::bsc_sfr_wr_t      sfr_wr;
    logic [7:0]                delay;
    logic                      crystal_oscillator_en;
    logic                      user_load_req;
    logic                      factory_load_req;
    logic [7:0]                boot_control_flags;
    logic [7:0]                boot_result_byte;
    logic                      boot_error;
    logic                      branch_start;
    logic [15:0]               branch_addr;
    logic                      force_exp;
    int                        failures;
    int                        checks_done;

    bsc_boot_flags bsc_boot_flags_i
    (
        .clk, .nrst, .npor, .boot_start, .general_pin_zero, .program_level,
        .proceed_after_factory_flag, .factory_load_done, .user_load_done, .load_result,
        .sfr_wr, .crystal_oscillator_en, .user_load_req, .factory_load_req,
        .boot_control_flags, .boot_result_byte, .boot_error, .branch_start, .branch_addr
    );

    bsc_copy_model bsc_copy_model_i
    (
        .clk, .nrst, .factory_load_req, .user_load_req, .delay, .result_cfg,
        .factory_load_done, .user_load_done, .load_result
    );

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // --------------------------------
    // helpers
    // --------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [7:0] exp_res(logic pn, logic usr, bsc_pkg::bsc_load_result_t r);
        return {pn, 2'h0, r.factory_load_error, usr & r.later_block_error, usr & r.first_block_error};
    endfunction

    task automatic power_cycle();
        npor = 1'h0;
        force_exp = 1'h0;
        @(negedge clk);
        npor = 1'h1;
    endtask

    // one full boot; bit 5 is set-only, so force_exp gathers ones until power_cycle
    task automatic boot(input bsc_pkg::bsc_level_t lv, input logic pr, input logic pn, input logic [7:0] wr,
                        input bsc_pkg::bsc_load_result_t r, input logic [7:0] dl);
        logic       usr;
        logic       seen_usr;
        logic       seen_br;
        logic [7:0] res;
        int         n;
        seen_usr = 1'h0;
        seen_br = 1'h0;
        nrst = 1'h0;
        @(negedge clk);
        nrst = 1'h1;
        program_level = lv;
        proceed_after_factory_flag = pr;
        result_cfg = r;
        delay = dl;
        force_exp = force_exp | wr[5];
        sfr_wr = '{1'h1, wr};
        @(negedge clk);
        sfr_wr.wr = 1'h0;
        cmp(boot_control_flags, {2'h0, force_exp, wr[4], 2'h0, wr[1:0]}, "ctrl write");
        general_pin_zero = pn;
        boot_start = 1'h1;
        @(negedge clk);
        boot_start = 1'h0;
        general_pin_zero = ~pn;
        cmp({crystal_oscillator_en, factory_load_req, boot_control_flags[1]}, 3'h6, "boot entry");
        for (n = 0; n < 300 && boot_control_flags[1] !== 1'h1; n++)
        begin
            @(negedge clk);
            seen_usr |= user_load_req;
            seen_br |= branch_start;
        end
        if (n == 300)
        begin
            failures++;
            $display("ERROR %0t boot never finished", $time);
            wrap_up();
        end
        @(negedge clk);
        seen_br |= branch_start;
        usr = (lv == bsc_pkg::BSC_LVL_RUN) || ((lv == bsc_pkg::BSC_LVL_USER) && pr && !force_exp);
        res = exp_res(pn, usr, r);
        cmp(boot_result_byte, res, "result byte");
        cmp(boot_error, !(res == 8'h00 || res == 8'h80), "error summary");
        cmp(boot_control_flags, {2'h0, force_exp, wr[4], 1'h0, res != 8'h00, 1'h1, wr[0]}, "ctrl end");
        cmp(seen_br, (wr[0] | wr[4]) && lv != bsc_pkg::BSC_LVL_RUN, "branch");
        cmp(branch_addr, 16'h0000, "branch address");
        cmp(seen_usr, usr, "user load");
        boot_start = 1'h1;
        @(negedge clk);
        boot_start = 1'h0;
        cmp(factory_load_req, 1'h0, "restart after done");
    endtask

    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        int                        i;
        logic [7:0]                w;
        bsc_pkg::bsc_level_t       lv;
        bsc_pkg::bsc_load_result_t r;
        failures = 0;
        checks_done = 0;
        nrst = 1'h0;
        npor = 1'h0;
        boot_start = 1'h0;
        general_pin_zero = 1'h0;
        program_level = bsc_pkg::BSC_LVL_FACTORY;
        proceed_after_factory_flag = 1'h0;
        result_cfg = '0;
        sfr_wr = '0;
        delay = 8'h00;
        force_exp = 1'h0;
        i = $urandom(23312);
        repeat (12) @(negedge clk);
        npor = 1'h1;
        nrst = 1'h1;
        @(negedge clk);
        // pin high alone is still a clean boot
        boot(bsc_pkg::BSC_LVL_USER, 1'h1, 1'h1, 8'h01, '0, 8'h00);
        for (i = 0; i < 8; i++)
            boot(bsc_pkg::BSC_LVL_FACTORY, 1'h1, 1'h0, 8'h10, '{i[2:0], 1'h1, 1'h1}, 8'h03);
        // forced factory behaviour must survive a system reset
        boot(bsc_pkg::BSC_LVL_USER, 1'h1, 1'h0, 8'h20, '{3'h0, 1'h1, 1'h1}, 8'h01);
        boot(bsc_pkg::BSC_LVL_USER, 1'h1, 1'h0, 8'hdf, '{3'h0, 1'h1, 1'h0}, 8'h00);
        power_cycle();
        boot(bsc_pkg::BSC_LVL_RUN, 1'h1, 1'h0, 8'h11, '0, 8'h02);
        for (i = 0; i < 40; i++)
        begin
            lv = bsc_pkg::bsc_level_t'($urandom_range(2));
            r = 5'($urandom);
            w = 8'($urandom) & 8'hdd;
            boot(lv, 1'($urandom), 1'($urandom), w, r, 8'($urandom_range(20)));
        end
        wrap_up();
    end
endmodule

`default_nettype wire

// >>> tb/bsc_copy_model.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------
// nvm copy engine behind the boot
// --------------------------------
module bsc_copy_model
(
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      factory_load_req,
    input  wire logic                      user_load_req,
    input  wire logic [7:0]                delay,
    input  wire bsc_pkg::bsc_load_result_t result_cfg,
    output logic                           factory_load_done,
    output logic                           user_load_done,
    output bsc_pkg::bsc_load_result_t      load_result
);
    int         cnt;
    logic       is_user;
    logic [4:0] noise;

    // result is only valid with done; a moving pattern otherwise so stale data is never trusted
    always @(negedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt               <= 0;
            is_user           <= 1'h0;
            noise             <= 5'h0a;
            factory_load_done <= 1'h0;
            user_load_done    <= 1'h0;
            load_result       <= bsc_pkg::bsc_load_result_t'(5'h15);
        end
        else
        begin
            noise             <= noise + 5'h0b;
            factory_load_done <= 1'h0;
            user_load_done    <= 1'h0;
            load_result       <= bsc_pkg::bsc_load_result_t'(noise);
            if (cnt == 1)
            begin
                factory_load_done <= !is_user;
                user_load_done    <= is_user;
                load_result       <= result_cfg;
            end
            if (cnt > 0)
                cnt <= cnt - 1;
            else if (factory_load_req || user_load_req)
            begin
                is_user <= user_load_req;
                cnt     <= int'(delay) + 1;
            end
        end
    end
endmodule

`default_nettype wire
